// ==== core/bhc_regs.svh ====
`ifndef BHC_REGS_SVH
`define BHC_REGS_SVH

`define BHC_BYTE_W        8
`define BHC_WORD_W        32
`define BHC_BYTES_PER_WORD 4
`define BHC_LAST_BYTE     2'h3
`define BHC_LINE_IDLE     1'h1
`define BHC_OWNER_PORTS   2
`define BHC_MAX_PORT      5
`define BHC_CLK_NS        10
`define BHC_WORD_GAP_NS   22
`define BHC_WORD_GAP_CYC  ((`BHC_WORD_GAP_NS + `BHC_CLK_NS - 1) / `BHC_CLK_NS)
`define BHC_SYNC_W        12

`endif

// ==== core/bhc_pkg.sv ====
`include "bhc_regs.svh"

package bhc_pkg;

  typedef enum logic [3:0] {
    BHC_IN_IDLE,
    BHC_IN_ASK,
    BHC_IN_TAKE,
    BHC_OUT_IDLE,
    BHC_OUT_SETUP,
    BHC_OUT_STB_LO,
    BHC_OUT_STB_HI,
    BHC_OUT_GAP,
    BHC_OUT_GIVE
  } bhc_state_t;

  // Synchronised pin bundle: {data, ack, req, ready, strobe}
  typedef logic [`BHC_SYNC_W-1:0] bhc_sync_t;

  typedef struct packed {
    bhc_state_t              st;
    logic [1:0]              idx;
    logic                    rx_phase;
    logic [3:0]              gap;
    logic [`BHC_WORD_W-1:0]  tx_word;
    logic [`BHC_WORD_W-1:0]  rx_word;
    bhc_sync_t               sy1;
    bhc_sync_t               sy2;
    logic [`BHC_BYTE_W-1:0]  data_out;
    logic                    data_oe;
    logic                    strobe_out;
    logic                    ack_out;
    logic                    ctl_oe;
    logic                    req_out;
    logic                    ready_out;
    logic                    rcv_oe;
    logic                    tx_ready;
    logic                    rx_valid;
    logic [`BHC_WORD_W-1:0]  rx_data;
    logic                    owns;
  } bhc_port_t;

  function automatic logic [`BHC_BYTE_W-1:0] byte_of(
    input logic [`BHC_WORD_W-1:0] word,
    input logic [1:0]             idx
  );
    byte_of = word[{idx, 3'h0} +: `BHC_BYTE_W];
  endfunction

  function automatic logic [`BHC_WORD_W-1:0] put_byte(
    input logic [`BHC_WORD_W-1:0] word,
    input logic [1:0]             idx,
    input logic [`BHC_BYTE_W-1:0] b
  );
    put_byte = word;
    put_byte[{idx, 3'h0} +: `BHC_BYTE_W] = b;
  endfunction

endpackage

// ==== core/bhc_link_if.sv ====
`include "bhc_regs.svh"

interface bhc_link_if;
  logic [`BHC_BYTE_W-1:0] a_data_out;
  logic                   a_data_oe;
  logic                   a_strobe_out;
  logic                   a_ack_out;
  logic                   a_ctl_oe;
  logic                   a_req_out;
  logic                   a_ready_out;
  logic                   a_rcv_oe;
  logic [`BHC_BYTE_W-1:0] b_data_out;
  logic                   b_data_oe;
  logic                   b_strobe_out;
  logic                   b_ack_out;
  logic                   b_ctl_oe;
  logic                   b_req_out;
  logic                   b_ready_out;
  logic                   b_rcv_oe;
  logic [`BHC_BYTE_W-1:0] port_data;
  logic                   byte_strobe;
  logic                   token_acknowledge;
  logic                   token_request;
  logic                   byte_ready;

  // Undriven lines float high, as pulled up on the board
  assign port_data = a_data_oe ? a_data_out : (b_data_oe ? b_data_out : 8'hFF);
  assign byte_strobe = a_ctl_oe ? a_strobe_out : (b_ctl_oe ? b_strobe_out : 1'h1);
  assign token_acknowledge = a_ctl_oe ? a_ack_out : (b_ctl_oe ? b_ack_out : 1'h1);
  assign token_request = a_rcv_oe ? a_req_out : (b_rcv_oe ? b_req_out : 1'h1);
  assign byte_ready = a_rcv_oe ? a_ready_out : (b_rcv_oe ? b_ready_out : 1'h1);

  modport dev (
    output a_data_out, a_data_oe, a_strobe_out, a_ack_out, a_ctl_oe,
    output a_req_out, a_ready_out, a_rcv_oe,
    input  port_data, byte_strobe, token_acknowledge, token_request, byte_ready
  );
  modport partner (
    output b_data_out, b_data_oe, b_strobe_out, b_ack_out, b_ctl_oe,
    output b_req_out, b_ready_out, b_rcv_oe,
    input  port_data, byte_strobe, token_acknowledge, token_request, byte_ready
  );
endinterface

// ==== core/bhc_port.sv ====
`include "bhc_regs.svh"

module bhc_port #(
  parameter int PORT_NUM = 0
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  bhc_link_if.dev                     link,
  input  wire logic                   tx_valid,
  input  wire logic [`BHC_WORD_W-1:0] tx_data,
  output logic                        tx_ready,
  output logic                        rx_valid,
  output logic [`BHC_WORD_W-1:0]      rx_data,
  output logic                        owns_output
);

  // Only ports zero to five exist; refuse anything else at elaboration
  if (PORT_NUM < 0 || PORT_NUM > `BHC_MAX_PORT) begin
    $error("PORT_NUM out of range");
  end

  localparam logic START_OWNER = (PORT_NUM <= `BHC_OWNER_PORTS);
  localparam logic [3:0] GAP_CYC = 4'(`BHC_WORD_GAP_CYC);

  localparam bhc_pkg::bhc_port_t RST = '{
    st:         START_OWNER ? bhc_pkg::BHC_OUT_IDLE : bhc_pkg::BHC_IN_IDLE,
    idx:        2'h0,
    rx_phase:   1'h0,
    gap:        4'h0,
    tx_word:    32'h0,
    rx_word:    32'h0,
    sy1:        12'hFFF,
    sy2:        12'hFFF,
    data_out:   8'hFF,
    data_oe:    START_OWNER,
    strobe_out: `BHC_LINE_IDLE,
    ack_out:    `BHC_LINE_IDLE,
    ctl_oe:     START_OWNER,
    req_out:    `BHC_LINE_IDLE,
    ready_out:  `BHC_LINE_IDLE,
    rcv_oe:     !START_OWNER,
    tx_ready:   1'h0,
    rx_valid:   1'h0,
    rx_data:    32'h0,
    owns:       START_OWNER
  };

  bhc_pkg::bhc_port_t r_reg;
  bhc_pkg::bhc_port_t r_next;

  logic                   strobe_s;
  logic                   ready_s;
  logic                   req_s;
  logic                   ack_s;
  logic [`BHC_BYTE_W-1:0] data_s;

  assign strobe_s = r_reg.sy2[0];
  assign ready_s  = r_reg.sy2[1];
  assign req_s    = r_reg.sy2[2];
  assign ack_s    = r_reg.sy2[3];
  assign data_s   = r_reg.sy2[11:4];

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    r_next = r_reg;
    r_next.sy1 = {link.port_data, link.token_acknowledge, link.token_request,
                  link.byte_ready, link.byte_strobe};
    r_next.sy2 = r_reg.sy1;
    r_next.rx_valid = 1'h0;
    r_next.tx_ready = 1'h0;

    // Receive side, live in every input state
    if (!r_reg.owns) begin
      if (!r_reg.rx_phase && !strobe_s) begin
        r_next.rx_word = bhc_pkg::put_byte(r_reg.rx_word, r_reg.idx, data_s);
        r_next.ready_out = 1'h0;
        r_next.rx_phase = 1'h1;
      end else if (r_reg.rx_phase && strobe_s) begin
        r_next.ready_out = 1'h1;
        r_next.rx_phase = 1'h0;
        r_next.idx = r_reg.idx + 2'h1;
        if (r_reg.idx == `BHC_LAST_BYTE) begin
          r_next.rx_valid = 1'h1;
          r_next.rx_data = r_reg.rx_word;
        end
      end
    end

    case (r_reg.st)
      bhc_pkg::BHC_IN_IDLE: begin
        // Ask only between words so the sender is never cut mid-word
        if (tx_valid && r_reg.idx == 2'h0 && !r_reg.rx_phase) begin
          r_next.req_out = 1'h0;
          r_next.st = bhc_pkg::BHC_IN_ASK;
        end
      end
      bhc_pkg::BHC_IN_ASK: begin
        if (!ack_s && r_reg.idx == 2'h0 && !r_reg.rx_phase) begin
          r_next.req_out = 1'h1;
          r_next.st = bhc_pkg::BHC_IN_TAKE;
        end
      end
      bhc_pkg::BHC_IN_TAKE: begin
        // Wait for old owner to let go of ack before driving it
        if (ack_s) begin
          r_next.rcv_oe = 1'h0;
          r_next.ctl_oe = 1'h1;
          r_next.data_oe = 1'h1;
          r_next.strobe_out = 1'h1;
          r_next.ack_out = 1'h1;
          r_next.owns = 1'h1;
          r_next.idx = 2'h0;
          r_next.st = bhc_pkg::BHC_OUT_IDLE;
          r_next.tx_ready = 1'h1;
        end
      end
      bhc_pkg::BHC_OUT_IDLE: begin
        if (tx_valid && r_reg.tx_ready) begin
          r_next.tx_word = tx_data;
          r_next.idx = 2'h0;
          r_next.data_out = bhc_pkg::byte_of(tx_data, 2'h0);
          r_next.st = bhc_pkg::BHC_OUT_SETUP;
        end else if (!req_s) begin
          r_next.ack_out = 1'h0;
          r_next.st = bhc_pkg::BHC_OUT_GIVE;
        end else begin
          r_next.tx_ready = 1'h1;
        end
      end
      bhc_pkg::BHC_OUT_SETUP: begin
        r_next.strobe_out = 1'h0;
        r_next.st = bhc_pkg::BHC_OUT_STB_LO;
      end
      bhc_pkg::BHC_OUT_STB_LO: begin
        // Data stays put until ready is seen low
        if (!ready_s) begin
          r_next.strobe_out = 1'h1;
          r_next.st = bhc_pkg::BHC_OUT_STB_HI;
        end
      end
      bhc_pkg::BHC_OUT_STB_HI: begin
        if (ready_s) begin
          if (r_reg.idx == `BHC_LAST_BYTE) begin
            r_next.idx = 2'h0;
            r_next.gap = GAP_CYC;
            r_next.st = bhc_pkg::BHC_OUT_GAP;
          end else begin
            r_next.idx = r_reg.idx + 2'h1;
            r_next.data_out = bhc_pkg::byte_of(r_reg.tx_word, r_reg.idx + 2'h1);
            r_next.st = bhc_pkg::BHC_OUT_SETUP;
          end
        end
      end
      bhc_pkg::BHC_OUT_GAP: begin
        // Counted after ready high, so well past the minimum after ready low
        if (r_reg.gap <= 4'h1) begin
          r_next.st = bhc_pkg::BHC_OUT_IDLE;
          r_next.tx_ready = req_s;
        end else begin
          r_next.gap = r_reg.gap - 4'h1;
        end
      end
      bhc_pkg::BHC_OUT_GIVE: begin
        if (req_s) begin
          r_next.ctl_oe = 1'h0;
          r_next.data_oe = 1'h0;
          r_next.ack_out = 1'h1;
          r_next.rcv_oe = 1'h1;
          r_next.req_out = 1'h1;
          r_next.ready_out = 1'h1;
          r_next.rx_phase = 1'h0;
          r_next.idx = 2'h0;
          r_next.owns = 1'h0;
          r_next.st = bhc_pkg::BHC_IN_IDLE;
        end
      end
      default: begin
        r_next.st = bhc_pkg::BHC_IN_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r_reg <= RST;
    end else begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign link.a_data_out   = r_reg.data_out;
  assign link.a_data_oe    = r_reg.data_oe;
  assign link.a_strobe_out = r_reg.strobe_out;
  assign link.a_ack_out    = r_reg.ack_out;
  assign link.a_ctl_oe     = r_reg.ctl_oe;
  assign link.a_req_out    = r_reg.req_out;
  assign link.a_ready_out  = r_reg.ready_out;
  assign link.a_rcv_oe     = r_reg.rcv_oe;
  assign tx_ready          = r_reg.tx_ready;
  assign rx_valid          = r_reg.rx_valid;
  assign rx_data           = r_reg.rx_data;
  assign owns_output       = r_reg.owns;

endmodule

// ==== core/bhc_partner.sv ====
`include "bhc_regs.svh"

module bhc_partner #(
  parameter bit START_OWNER = 1'b0
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  bhc_link_if.partner                 link,
  input  wire logic                   tx_valid,
  input  wire logic [`BHC_WORD_W-1:0] tx_data,
  output logic                        tx_ready,
  output logic                        rx_valid,
  output logic [`BHC_WORD_W-1:0]      rx_data,
  output logic                        owns_output
);

  localparam bhc_pkg::bhc_port_t RST = '{
    st:         START_OWNER ? bhc_pkg::BHC_OUT_IDLE : bhc_pkg::BHC_IN_IDLE,
    idx:        2'h0, rx_phase: 1'h0, gap: 4'h0, tx_word: 32'h0, rx_word: 32'h0,
    sy1:        12'hFFF, sy2: 12'hFFF, data_out: 8'hFF, data_oe: START_OWNER,
    strobe_out: 1'h1, ack_out: 1'h1, ctl_oe: START_OWNER, req_out: 1'h1,
    ready_out:  1'h1, rcv_oe: !START_OWNER, tx_ready: 1'h0, rx_valid: 1'h0,
    rx_data:    32'h0, owns: START_OWNER
  };

  bhc_pkg::bhc_port_t r_reg;
  bhc_pkg::bhc_port_t r_next;
  logic strobe_s;
  logic ready_s;
  logic req_s;
  logic ack_s;

  assign strobe_s = r_reg.sy2[0];
  assign ready_s  = r_reg.sy2[1];
  assign req_s    = r_reg.sy2[2];
  assign ack_s    = r_reg.sy2[3];

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    r_next = r_reg;
    r_next.sy1 = {link.port_data, link.token_acknowledge, link.token_request,
                  link.byte_ready, link.byte_strobe};
    r_next.sy2 = r_reg.sy1;
    r_next.rx_valid = 1'h0;
    r_next.tx_ready = 1'h0;
    if (!r_reg.owns) begin
      if (!r_reg.rx_phase && !strobe_s) begin
        r_next.rx_word = bhc_pkg::put_byte(r_reg.rx_word, r_reg.idx, r_reg.sy2[11:4]);
        r_next.ready_out = 1'h0;
        r_next.rx_phase = 1'h1;
      end else if (r_reg.rx_phase && strobe_s) begin
        r_next.ready_out = 1'h1;
        r_next.rx_phase = 1'h0;
        r_next.idx = r_reg.idx + 2'h1;
        if (r_reg.idx == `BHC_LAST_BYTE) begin
          r_next.rx_valid = 1'h1;
          r_next.rx_data = r_reg.rx_word;
        end
      end
    end
    case (r_reg.st)
      bhc_pkg::BHC_IN_IDLE: begin
        if (tx_valid && r_reg.idx == 2'h0 && !r_reg.rx_phase) begin
          r_next.req_out = 1'h0;
          r_next.st = bhc_pkg::BHC_IN_ASK;
        end
      end
      bhc_pkg::BHC_IN_ASK: begin
        if (!ack_s && r_reg.idx == 2'h0 && !r_reg.rx_phase) begin
          r_next.req_out = 1'h1;
          r_next.st = bhc_pkg::BHC_IN_TAKE;
        end
      end
      bhc_pkg::BHC_IN_TAKE: begin
        if (ack_s) begin
          r_next.rcv_oe = 1'h0;
          r_next.ctl_oe = 1'h1;
          r_next.data_oe = 1'h1;
          r_next.owns = 1'h1;
          r_next.idx = 2'h0;
          r_next.st = bhc_pkg::BHC_OUT_IDLE;
          r_next.tx_ready = 1'h1;
        end
      end
      bhc_pkg::BHC_OUT_IDLE: begin
        if (tx_valid && r_reg.tx_ready) begin
          r_next.tx_word = tx_data;
          r_next.idx = 2'h0;
          r_next.data_out = bhc_pkg::byte_of(tx_data, 2'h0);
          r_next.st = bhc_pkg::BHC_OUT_SETUP;
        end else if (!req_s) begin
          r_next.ack_out = 1'h0;
          r_next.st = bhc_pkg::BHC_OUT_GIVE;
        end else begin
          r_next.tx_ready = 1'h1;
        end
      end
      bhc_pkg::BHC_OUT_SETUP: begin
        r_next.strobe_out = 1'h0;
        r_next.st = bhc_pkg::BHC_OUT_STB_LO;
      end
      bhc_pkg::BHC_OUT_STB_LO: begin
        if (!ready_s) begin
          r_next.strobe_out = 1'h1;
          r_next.st = bhc_pkg::BHC_OUT_STB_HI;
        end
      end
      bhc_pkg::BHC_OUT_STB_HI: begin
        if (ready_s) begin
          if (r_reg.idx == `BHC_LAST_BYTE) begin
            r_next.idx = 2'h0;
            r_next.st = bhc_pkg::BHC_OUT_IDLE;
          end else begin
            r_next.idx = r_reg.idx + 2'h1;
            r_next.data_out = bhc_pkg::byte_of(r_reg.tx_word, r_reg.idx + 2'h1);
            r_next.st = bhc_pkg::BHC_OUT_SETUP;
          end
        end
      end
      bhc_pkg::BHC_OUT_GIVE: begin
        if (req_s) begin
          r_next.ctl_oe = 1'h0;
          r_next.data_oe = 1'h0;
          r_next.ack_out = 1'h1;
          r_next.rcv_oe = 1'h1;
          r_next.req_out = 1'h1;
          r_next.ready_out = 1'h1;
          r_next.rx_phase = 1'h0;
          r_next.idx = 2'h0;
          r_next.owns = 1'h0;
          r_next.st = bhc_pkg::BHC_IN_IDLE;
        end
      end
      default: begin
        r_next.st = bhc_pkg::BHC_IN_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r_reg <= RST;
    end else begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign link.b_data_out   = r_reg.data_out;
  assign link.b_data_oe    = r_reg.data_oe;
  assign link.b_strobe_out = r_reg.strobe_out;
  assign link.b_ack_out    = r_reg.ack_out;
  assign link.b_ctl_oe     = r_reg.ctl_oe;
  assign link.b_req_out    = r_reg.req_out;
  assign link.b_ready_out  = r_reg.ready_out;
  assign link.b_rcv_oe     = r_reg.rcv_oe;
  assign tx_ready          = r_reg.tx_ready;
  assign rx_valid          = r_reg.rx_valid;
  assign rx_data           = r_reg.rx_data;
  assign owns_output       = r_reg.owns;

endmodule

// ==== verification/bhc_link_sva.sv ====
`include "bhc_regs.svh"

module bhc_link_sva (
  input wire logic                   clk,
  input wire logic                   rst_n,
  input wire logic [`BHC_BYTE_W-1:0] port_data,
  input wire logic                   byte_strobe,
  input wire logic                   byte_ready,
  input wire logic                   token_request,
  input wire logic                   token_acknowledge
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] idx_reg;
  logic [3:0] since_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////////
  // Byte position in the word, advanced when the receiver closes a byte
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      idx_reg   <= 2'h0;
      since_reg <= 4'hF;
    end else begin
      if ($rose(byte_ready))
        idx_reg <= idx_reg + 2'h1;
      // Saturates so a long idle never wraps into a short gap
      if ($fell(byte_ready))
        since_reg <= 4'h0;
      else if (since_reg != 4'hF)
        since_reg <= since_reg + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  AST_DATA_BEFORE_STROBE: assert property (
    $fell(byte_strobe) |-> $stable(port_data)) else $error("data moved with strobe fall");
  AST_DATA_HELD: assert property (
    !byte_strobe && byte_ready |=> $stable(port_data)) else $error("data moved before ready");
  AST_READY_AFTER_STROBE: assert property (
    $fell(byte_ready) |-> !byte_strobe && !$past(byte_strobe, 2))
    else $error("ready fell without synced strobe low");
  AST_READY_ANSWER: assert property (
    $fell(byte_strobe) |-> ##[1:4] $fell(byte_ready)) else $error("ready did not answer strobe");
  AST_STROBE_RELEASE: assert property (
    $fell(byte_ready) |-> ##[1:4] $rose(byte_strobe)) else $error("strobe not released");
  AST_STROBE_HIGH_ORDER: assert property (
    $rose(byte_strobe) |-> !byte_ready) else $error("strobe rose while ready high");
  AST_READY_RETURN: assert property (
    $rose(byte_strobe) |-> ##[1:4] $rose(byte_ready)) else $error("ready did not return");
  AST_READY_HIGH_ORDER: assert property (
    $rose(byte_ready) |-> byte_strobe && $past(byte_strobe, 2))
    else $error("ready rose before strobe high");
  AST_NEXT_BYTE_WAITS: assert property (
    $fell(byte_strobe) |-> byte_ready && $past(byte_ready, 2))
    else $error("strobe fell before ready high");
  AST_WORD_GAP: assert property (
    $fell(byte_strobe) && idx_reg == 2'h0 |-> since_reg >= 4'h2) else $error("word gap short");
  AST_TOKEN_BETWEEN_WORDS: assert property (
    $fell(token_acknowledge) |-> idx_reg == 2'h0 && byte_strobe)
    else $error("token moved inside a word");

  cover property ($rose(byte_ready) && idx_reg == 2'h3);
  cover property ($fell(token_acknowledge));
  cover property ($fell(byte_strobe) && idx_reg == 2'h0 && since_reg < 4'hF);
endmodule

// ==== verification/tb_byte_handshake_comm_port.sv ====
`include "bhc_regs.svh"

module tb_byte_handshake_comm_port;
  timeunit 1ns;
  timeprecision 1ps;

  logic                   clk;
  logic                   rst_n;
  logic                   a_tx_valid;
  logic [`BHC_WORD_W-1:0] a_tx_data;
  logic                   a_tx_ready;
  logic                   a_rx_valid;
  logic [`BHC_WORD_W-1:0] a_rx_data;
  logic                   a_owns;
  logic                   b_tx_valid;
  logic [`BHC_WORD_W-1:0] b_tx_data;
  logic                   b_tx_ready;
  logic                   b_rx_valid;
  logic [`BHC_WORD_W-1:0] b_rx_data;
  logic                   b_owns;
  logic                   c_owns;
  logic                   c_tx_valid;
  logic                   d_owns;
  int                     miscompares;
  int                     checks;
  logic [`BHC_WORD_W-1:0] qa[$];
  logic [`BHC_WORD_W-1:0] qb[$];
  logic [`BHC_WORD_W-1:0] qw[$];
  logic [1:0]             widx;
  logic                   prev_stb;
  logic [`BHC_WORD_W-1:0] corner[5] = '{32'h00000000, 32'hFFFFFFFF, 32'h000000FF,
                                        32'hFF000000, 32'h01020304};

  bhc_link_if link ();
  bhc_link_if link_in ();

  bhc_port #(.PORT_NUM(0)) u_bhc_port (
    .clk (clk), .rst_n (rst_n), .link (link), .tx_valid (a_tx_valid), .tx_data (a_tx_data),
    .tx_ready (a_tx_ready), .rx_valid (a_rx_valid), .rx_data (a_rx_data), .owns_output (a_owns)
  );
  bhc_partner #(.START_OWNER(1'b0)) u_bhc_partner (
    .clk (clk), .rst_n (rst_n), .link (link), .tx_valid (b_tx_valid), .tx_data (b_tx_data),
    .tx_ready (b_tx_ready), .rx_valid (b_rx_valid), .rx_data (b_rx_data), .owns_output (b_owns)
  );
  // Second pair proves the reset direction of an upper port and one token move
  bhc_port #(.PORT_NUM(3)) u_bhc_port_in (
    .clk (clk), .rst_n (rst_n), .link (link_in), .tx_valid (c_tx_valid), .tx_data (a_tx_data),
    .tx_ready (), .rx_valid (), .rx_data (), .owns_output (c_owns)
  );
  bhc_partner #(.START_OWNER(1'b1)) u_bhc_partner_out (
    .clk (clk), .rst_n (rst_n), .link (link_in), .tx_valid (1'h0), .tx_data (b_tx_data),
    .tx_ready (), .rx_valid (), .rx_data (), .owns_output (d_owns)
  );
  bhc_link_sva u_bhc_link_sva (
    .clk (clk), .rst_n (rst_n), .port_data (link.port_data), .byte_strobe (link.byte_strobe),
    .byte_ready (link.byte_ready), .token_request (link.token_request),
    .token_acknowledge (link.token_acknowledge)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial clk = 1'h0;
  always #5 clk = ~clk;

  function automatic logic [7:0] exp_byte(input logic [31:0] w, input logic [1:0] i);
    exp_byte = w[{i, 3'h0} +: 8];
  endfunction

  task automatic cmp32(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cmp8(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cmp1(input string name, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic final_report();
    if (miscompares == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Holds valid until the edge that takes the word; caller keeps it up for back-to-back
  task automatic send(input bit side, input logic [31:0] w);
    int n;
    n = 0;
    if (side) begin
      b_tx_valid <= 1'h1;
      b_tx_data  <= w;
    end else begin
      a_tx_valid <= 1'h1;
      a_tx_data  <= w;
    end
    do begin
      @(posedge clk);
      n++;
    end while ((side ? b_tx_ready : a_tx_ready) !== 1'h1 && n < 3000);
    if (n >= 3000)
      miscompares++;
    qw.push_back(w);
    if (side)
      qa.push_back(w);
    else
      qb.push_back(w);
  endtask

  task automatic burst(input bit side, input int count);
    for (int k = 0; k < count; k++) begin
      send(side, k < 5 ? corner[k] : $urandom);
      if ($urandom_range(0, 1) == 0 || k == count - 1) begin
        if (side)
          b_tx_valid <= 1'h0;
        else
          a_tx_valid <= 1'h0;
        repeat ($urandom_range(1, 4)) @(posedge clk);
      end
    end
  endtask

  task automatic wait_drain();
    for (int n = 0; n < 3000 && qa.size() + qb.size() + qw.size() != 0; n++)
      @(posedge clk);
    if (qa.size() + qb.size() + qw.size() != 0)
      miscompares++;
    repeat (8) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (rst_n === 1'h1 && a_rx_valid === 1'h1)
      cmp32("port rx word", qa.size() != 0 ? qa.pop_front() : 32'hX, a_rx_data);
    if (rst_n === 1'h1 && b_rx_valid === 1'h1)
      cmp32("partner rx word", qb.size() != 0 ? qb.pop_front() : 32'hX, b_rx_data);
  end

  // Every byte on the wire is judged at the edge its strobe is first seen low
  always @(posedge clk) begin
    if (rst_n !== 1'h1)
      widx = 2'h0;
    else if (prev_stb === 1'h1 && link.byte_strobe === 1'h0) begin
      cmp8("wire byte", exp_byte(qw.size() != 0 ? qw[0] : 32'hX, widx), link.port_data);
      if (widx == 2'h3 && qw.size() != 0)
        void'(qw.pop_front());
      widx = widx + 2'h1;
    end
    prev_stb = link.byte_strobe;
  end

  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    final_report();
  end

  initial begin
    rst_n       = 1'h0;
    a_tx_valid  = 1'h0;
    a_tx_data   = 32'h0;
    b_tx_valid  = 1'h0;
    b_tx_data   = 32'h0;
    c_tx_valid  = 1'h0;
    miscompares = 0;
    checks      = 0;
    widx        = 2'h0;
    prev_stb    = 1'h1;
    void'($urandom(32'h0034B905));
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    repeat (3) @(posedge clk);
    cmp1("port owns", 1'h1, a_owns);
    cmp1("partner owns", 1'h0, b_owns);
    cmp1("upper port owns", 1'h0, c_owns);
    cmp1("upper partner owns", 1'h1, d_owns);
    cmp1("idle strobe", 1'h1, link.byte_strobe);
    burst(1'h0, 12);
    wait_drain();
    burst(1'h1, 9);
    wait_drain();
    cmp1("port owns after swap", 1'h0, a_owns);
    cmp1("partner owns after swap", 1'h1, b_owns);
    burst(1'h0, 8);
    wait_drain();
    cmp1("port owns again", 1'h1, a_owns);
    cmp1("idle ready", 1'h1, link.byte_ready);
    // Upper port asks its idle owner for the token
    c_tx_valid <= 1'h1;
    for (int n = 0; n < 200 && c_owns !== 1'h1; n++)
      @(posedge clk);
    c_tx_valid <= 1'h0;
    cmp1("upper port owns after ask", 1'h1, c_owns);
    cmp1("upper partner owns after ask", 1'h0, d_owns);
    final_report();
  end
endmodule
